// ### core/gpd_pkg.sv
//==============================================================================
// Overview of operation
// - An analog-capable pin in digital mode is an input when its direction bit is 0, an output when 1.
// - Reading the analog pin direction register returns bits 2, 4, 6, 10, 12 and 14 only, the rest zero.
// - While the external reset pin is low, pull-ups of pins 0 to 11 are forced off asynchronously.
// - Reset enables the pull-ups of every pin other than pins 0 to 11.
// - After reset each pull-up keeps its default until software writes its disable bit.
// - The pull-up setting applies whether the pin is general I/O or a peripheral function.
// - Port A pull-up disable bits 31-0, 0 enables, 1 disables, reset 1 for pins 0-11 else 0.
// - Port B pull-up disable bits 6-0 for pins 32-38, reset 0, bits 31-7 read zero.
// - Reading a port data register returns the qualified pin levels, not the output latch.
// - Writing port data drives pins enabled as general outputs, otherwise only latches.
// - Each output latch bit holds its last written value until the next write, except analog latch bits other than 2, 4, 6, 10, 12 and 14, which stay zero.
// - Reset clears every output latch bit to zero; data register reads still return the pin levels.
// - Port A data read right after reset follows the external pin levels.
// - Pull-up disable writes are accepted only while the write-protect unlock is active.
// - Each port A data bit is one pin and forces its level only when it is a general output.
//==============================================================================
package gpd_pkg;
   // register byte offsets
   localparam logic [7:0]  OFS_AIO_DIR   = 8'h00;
   localparam logic [7:0]  OFS_A_PUD     = 8'h04;
   localparam logic [7:0]  OFS_B_PUD     = 8'h08;
   localparam logic [7:0]  OFS_A_DAT     = 8'h0C;
   localparam logic [7:0]  OFS_AIO_DAT   = 8'h10;
   // implemented bit masks and reset values
   localparam logic [31:0] AIO_DIR_MASK  = 32'h0000_5454;
   localparam logic [31:0] A_PUD_RESET   = 32'h0000_0FFF;
   localparam logic [31:0] A_PWM_MASK    = 32'h0000_0FFF;
   localparam logic [31:0] B_PUD_MASK    = 32'h0000_007F;
   localparam logic [31:0] B_PUD_RESET   = 32'h0000_0000;
   localparam logic [31:0] ZERO_WORD     = 32'h0000_0000;
endpackage : gpd_pkg

// ### core/gpd_reg32.sv
`timescale 1ns/1ns
`default_nettype none
//==============================================================================
// masked 32-bit register with reset value and write enable
module gpd_reg32 #(
   parameter logic [31:0] MASK  = 32'hFFFF_FFFF,
   parameter logic [31:0] RESET = 32'h0000_0000
) (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        wr_en,
   input  wire logic [31:0] wr_data,
   output var  logic [31:0] q
);
   logic [31:0] q_reg;
   logic [31:0] q_next;

   // reserved bits never change and stay zero
   always_comb begin
      q_next = q_reg;
      if (wr_en) begin
         q_next = wr_data & MASK;
      end
   end

   // sync reset load
   always_ff @(posedge clk) begin
      if (!rst_n) begin
         q_reg <= RESET & MASK;
      end else begin
         q_reg <= q_next;
      end
   end

   assign q = q_reg;
endmodule : gpd_reg32
`default_nettype wire

// ### core/gpd_top.sv
`timescale 1ns/1ns
`default_nettype none
//==============================================================================
// pull-up, analog direction and port A data block
module gpd_top (
   input  wire logic        clk,
   input  wire logic        rst_n,
   input  wire logic        ext_reset_n,
   input  wire logic        psel,
   input  wire logic        penable,
   input  wire logic        pwrite,
   input  wire logic [7:0]  paddr,
   input  wire logic [31:0] pwdata,
   output var  logic [31:0] prdata,
   output var  logic        pready,
   output var  logic        pslverr,
   input  wire logic        write_protect_unlock,
   input  wire logic [31:0] port_a_gpio_out_en,
   input  wire logic [31:0] port_a_qual_in,
   input  wire logic [14:0] aio_digital_mode,
   input  wire logic [14:0] aio_qual_in,
   output var  logic [31:0] port_a_out,
   output var  logic [31:0] port_a_oe,
   output var  logic [31:0] port_a_pullup_en,
   output var  logic [6:0]  port_b_pullup_en,
   output var  logic [14:0] aio_out,
   output var  logic [14:0] aio_oe
);
   import gpd_pkg::*;

   //===========================================================================
   // bus decode
   logic        wr_acc;
   logic        rd_acc;
   logic        hit;
   logic [31:0] aio_dir_q;
   logic [31:0] a_pud_q;
   logic [31:0] b_pud_q;
   logic [31:0] a_lat_q;
   logic [31:0] aio_lat_q;
   logic [31:0] rd_mux;
   logic [31:0] prdata_reg;
   logic [31:0] prdata_next;
   logic        err_reg;
   logic        err_next;

   // zero-wait slave, pready tied high; one access is one setup plus one access cycle
   assign wr_acc = psel && penable && pwrite;
   assign rd_acc = psel && !penable && !pwrite;
   assign pready = 1'b1;

   // address hit check
   always_comb begin
      case (paddr)
         OFS_AIO_DIR, OFS_A_PUD, OFS_B_PUD, OFS_A_DAT, OFS_AIO_DAT: hit = 1'b1;
         default: hit = 1'b0;
      endcase
   end

   //===========================================================================
   // registers
   gpd_reg32 #(.MASK(AIO_DIR_MASK), .RESET(ZERO_WORD)) u_aio_dir (
      .clk     (clk),
      .rst_n   (rst_n),
      .wr_en   (wr_acc && paddr == OFS_AIO_DIR),
      .wr_data (pwdata),
      .q       (aio_dir_q)
   );

   // pull-up regs only take writes while unlocked
   gpd_reg32 #(.MASK(32'hFFFF_FFFF), .RESET(A_PUD_RESET)) u_a_pud (
      .clk     (clk),
      .rst_n   (rst_n),
      .wr_en   (wr_acc && paddr == OFS_A_PUD && write_protect_unlock),
      .wr_data (pwdata),
      .q       (a_pud_q)
   );

   gpd_reg32 #(.MASK(B_PUD_MASK), .RESET(B_PUD_RESET)) u_b_pud (
      .clk     (clk),
      .rst_n   (rst_n),
      .wr_en   (wr_acc && paddr == OFS_B_PUD && write_protect_unlock),
      .wr_data (pwdata),
      .q       (b_pud_q)
   );

   // output latches hold until next write, cleared on reset
   gpd_reg32 #(.MASK(32'hFFFF_FFFF), .RESET(ZERO_WORD)) u_a_lat (
      .clk     (clk),
      .rst_n   (rst_n),
      .wr_en   (wr_acc && paddr == OFS_A_DAT),
      .wr_data (pwdata),
      .q       (a_lat_q)
   );

   gpd_reg32 #(.MASK(AIO_DIR_MASK), .RESET(ZERO_WORD)) u_aio_lat (
      .clk     (clk),
      .rst_n   (rst_n),
      .wr_en   (wr_acc && paddr == OFS_AIO_DAT),
      .wr_data (pwdata),
      .q       (aio_lat_q)
   );

   //===========================================================================
   // read mux: data reads show pins, not latches
   always_comb begin
      case (paddr)
         OFS_AIO_DIR: rd_mux = aio_dir_q & AIO_DIR_MASK;
         OFS_A_PUD:   rd_mux = a_pud_q;
         OFS_B_PUD:   rd_mux = b_pud_q & B_PUD_MASK;
         OFS_A_DAT:   rd_mux = port_a_qual_in;
         OFS_AIO_DAT: rd_mux = {17'h0, aio_qual_in} & AIO_DIR_MASK;
         default:     rd_mux = ZERO_WORD;
      endcase
   end

   // read data captured in setup cycle, stable through access phase
   always_comb begin
      prdata_next = prdata_reg;
      err_next    = 1'b0;
      if (rd_acc) begin
         prdata_next = rd_mux;
      end
      if (psel && !penable) begin
         err_next = !hit;
      end
   end

   always_ff @(posedge clk) begin
      if (!rst_n) begin
         prdata_reg <= ZERO_WORD;
         err_reg    <= 1'b0;
      end else begin
         prdata_reg <= prdata_next;
         err_reg    <= err_next;
      end
   end

   assign prdata  = prdata_reg;
   assign pslverr = err_reg && psel && penable;

   //===========================================================================
   // pin drive; external reset kills pwm-pin pull-ups without the clock
   always_comb begin
      port_a_out       = a_lat_q;
      port_a_oe        = port_a_gpio_out_en;
      port_a_pullup_en = ~a_pud_q;
      if (!ext_reset_n) begin
         port_a_pullup_en = ~a_pud_q & ~A_PWM_MASK;
      end
      port_b_pullup_en = ~b_pud_q[6:0];
      aio_out          = aio_lat_q[14:0];
      aio_oe           = aio_digital_mode & aio_dir_q[14:0];
   end
endmodule : gpd_top
`default_nettype wire

// ### tb/gpd_checker.sv
`timescale 1ns/1ns
`default_nettype none
//==============================================================================
// port checks: pull-ups, latch, pin reads
module gpd_checker
   import gpd_pkg::*;
(
   input wire logic        clk,
   input wire logic        rst_n,
   input wire logic        ext_reset_n,
   input wire logic        psel,
   input wire logic        penable,
   input wire logic        pwrite,
   input wire logic [7:0]  paddr,
   input wire logic [31:0] pwdata,
   input wire logic [31:0] prdata,
   input wire logic        write_protect_unlock,
   input wire logic [31:0] port_a_gpio_out_en,
   input wire logic [31:0] port_a_qual_in,
   input wire logic [14:0] aio_digital_mode,
   input wire logic [31:0] port_a_out,
   input wire logic [31:0] port_a_oe,
   input wire logic [31:0] port_a_pullup_en,
   input wire logic [6:0]  port_b_pullup_en,
   input wire logic [14:0] aio_oe
);
   default clocking cb @(posedge clk); endclocking
   default disable iff (!rst_n);
   // access-phase write strobe
   wire logic wr = psel & penable & pwrite;
   a_oe_follow: assert property (port_a_oe == port_a_gpio_out_en)
      else $error("oe differs from gpio enable");
   a_aio_oe_mode: assert property ((aio_oe & ~(aio_digital_mode & AIO_DIR_MASK[14:0])) == 15'h0)
      else $error("aio oe without mode or bit");
   a_ext_pull_off: assert property (!ext_reset_n |-> port_a_pullup_en[11:0] == 12'h000)
      else $error("pull-up on while pin reset low");
   a_reset_pull: assert property ($rose(rst_n) && ext_reset_n |-> port_a_pullup_en == 32'hFFFF_F000
      && port_b_pullup_en == 7'h7F && port_a_out == 32'h0)
      else $error("reset defaults wrong");
   a_pud_locked: assert property (wr && !write_protect_unlock && ext_reset_n |=> !ext_reset_n
      || ($stable(port_a_pullup_en) && $stable(port_b_pullup_en)))
      else $error("locked pull-up write took effect");
   a_pud_write: assert property (wr && write_protect_unlock && paddr == OFS_A_PUD |=> !ext_reset_n
      || port_a_pullup_en == ~$past(pwdata))
      else $error("pull-up write not applied");
   a_out_write: assert property (wr && paddr == OFS_A_DAT |=> port_a_out == $past(pwdata))
      else $error("latch not written");
   a_out_hold: assert property (!(wr && paddr == OFS_A_DAT) |=> $stable(port_a_out))
      else $error("latch changed without write");
   a_read_pins: assert property (psel && !penable && !pwrite && paddr == OFS_A_DAT
      |=> prdata == $past(port_a_qual_in))
      else $error("data read not pin level");
endmodule : gpd_checker
`default_nettype wire

// ### tb/gpd_pins.sv
`timescale 1ns/1ns
`default_nettype none
//==============================================================================
// board side: driven pins, board drivers, pull-ups, else drifting
module gpd_pins (
   input  wire logic        clk,
   input  wire logic [31:0] pin_out,
   input  wire logic [31:0] pin_oe,
   input  wire logic [31:0] pull_en,
   input  wire logic [31:0] drv_en,
   input  wire logic [31:0] drv_lvl,
   output var  logic [31:0] qual
);
   logic [31:0] flt_reg = 32'h0;
   // undriven pin without pull-up wanders each cycle
   always_ff @(posedge clk) flt_reg <= ~flt_reg;
   // pull-up counts whatever the pin's function
   assign qual = (pin_oe & pin_out) | (~pin_oe & drv_en & drv_lvl)
      | (~pin_oe & ~drv_en & (pull_en | flt_reg));
endmodule : gpd_pins
`default_nettype wire

// ### tb/test_gpd_top.sv
`timescale 1ns/1ns
`default_nettype none
//==============================================================================
module test_gpd_top;
   import gpd_pkg::*;
   logic        clk, rst_n, ext_reset_n, psel, penable, pwrite, unl, pready, pslverr;
   logic [7:0]  paddr;
   logic [31:0] pwdata, en, drv, lvl, qual, prdata, a_out, a_oe, a_pu, pud_m, out_m, r, m, d;
   logic [14:0] mode, aq, aio_out, aio_oe;
   logic [6:0]  b_pu;
   logic        e;
   logic [7:0]  ta [4] = '{OFS_A_PUD, OFS_A_PUD, OFS_B_PUD, OFS_AIO_DIR};
   logic [31:0] te [4] = '{A_PUD_RESET, 32'hFFFF_FFFF, B_PUD_MASK, AIO_DIR_MASK};
   integer      errors = 0, cmp_count = 0, seed = 32'h9992, i;
   gpd_top i_gpd_top (.clk, .rst_n, .ext_reset_n, .psel, .penable, .pwrite, .paddr, .pwdata,
      .prdata, .pready, .pslverr, .write_protect_unlock(unl), .port_a_gpio_out_en(en),
      .port_a_qual_in(qual), .aio_digital_mode(mode), .aio_qual_in(aq), .port_a_out(a_out),
      .port_a_oe(a_oe), .port_a_pullup_en(a_pu), .port_b_pullup_en(b_pu), .aio_out, .aio_oe);
   gpd_pins i_gpd_pins (.clk, .pin_out(a_out), .pin_oe(a_oe), .pull_en(a_pu), .drv_en(drv),
      .drv_lvl(lvl), .qual);
   // clock, and a watchdog far beyond the few hundred cycles needed
   always #25 clk = ~clk;
   initial begin
      #250000;
      errors++;
      stop_test();
   end
   task automatic chk(input string s, input logic [31:0] seen, input logic [31:0] exp);
      cmp_count++;
      if (seen !== exp) begin
         errors++;
         $display("BAD %s expected %h seen %h", s, exp, seen);
      end
   endtask : chk
   // one apb transfer, entered just after a rising edge
   task automatic xfer(input logic [7:0] a, input logic w, input logic [31:0] v);
      integer k;
      k = 0;
      psel <= 1'b1; penable <= 1'b0; pwrite <= w; paddr <= a; pwdata <= v;
      @(posedge clk) penable <= 1'b1;
      @(posedge clk);
      while (pready !== 1'b1 && k < 16) begin
         k++;
         @(posedge clk);
      end
      r = prdata;
      e = pslverr;
      psel <= 1'b0; penable <= 1'b0;
      @(posedge clk);
   endtask : xfer
   task stop_test;
      if (errors == 0 && cmp_count > 0) $display("Run complete: PASS");
      else $display("Run complete: FAIL");
      $finish;
   endtask : stop_test
   // main sequence against a shadow of latch and pull-up state
   initial begin
      {clk, rst_n, psel, penable, pwrite, unl, ext_reset_n} = 7'h01;
      {paddr, pwdata, en, drv, lvl, mode, aq} = 'h0;
      repeat (12) @(posedge clk);
      rst_n <= 1'b1;
      @(posedge clk);
      chk("pull a", a_pu, ~A_PUD_RESET);
      chk("pull b", 32'(b_pu), 32'h7F);
      chk("latch", a_out, 32'h0);
      xfer(OFS_AIO_DIR, 1'b0, 32'h0);
      chk("aio dir", r, 32'h0);
      for (i = 0; i < 4; i++) begin
         unl <= (i != 0);
         xfer(ta[i], 1'b1, 32'hFFFF_FFFF);
         xfer(ta[i], 1'b0, 32'h0);
         chk("reg", r, te[i]);
         chk("slverr mapped", 32'(e), 32'h0);
      end
      pud_m = 32'hFFFF_FFFF;
      mode <= 15'($random(seed));
      @(posedge clk);
      @(posedge clk);
      chk("aio oe", 32'(aio_oe), 32'(mode & AIO_DIR_MASK[14:0]));
      for (i = 0; i < 24; i++) begin
         en <= $random(seed); drv <= $random(seed); lvl <= $random(seed);
         aq <= 15'($random(seed));
         ext_reset_n <= (i % 4 != 3); unl <= 1'($random(seed));
         @(posedge clk);
         d = $random(seed);
         xfer(OFS_A_PUD, 1'b1, d);
         if (unl) pud_m = d;
         xfer(OFS_A_DAT, 1'b1, ~d);
         out_m = ~d;
         chk("out", a_out, out_m);
         chk("oe", a_oe, en);
         m = ~pud_m & (ext_reset_n ? 32'hFFFF_FFFF : ~A_PWM_MASK);
         chk("pull", a_pu, m);
         xfer(OFS_A_DAT, 1'b0, 32'h0);
         chk("pins", r & (en | drv | m), (en & out_m) | (~en & drv & lvl) | (~en & ~drv & m));
      end
      xfer(OFS_AIO_DAT, 1'b1, 32'hFFFF_FFFF);
      chk("aio out", 32'(aio_out), 32'(AIO_DIR_MASK[14:0]));
      xfer(OFS_AIO_DAT, 1'b0, 32'h0);
      chk("aio pins", r, {17'h0, aq} & AIO_DIR_MASK);
      xfer(8'h40, 1'b0, 32'h0);
      chk("unmapped", r, 32'h0);
      chk("slverr", 32'(e), 32'h1);
      stop_test();
   end
endmodule : test_gpd_top
bind gpd_top gpd_checker i_gpd_checker (.clk, .rst_n, .ext_reset_n, .psel, .penable, .pwrite,
   .paddr, .pwdata, .prdata, .write_protect_unlock, .port_a_gpio_out_en, .port_a_qual_in,
   .aio_digital_mode, .port_a_out, .port_a_oe, .port_a_pullup_en, .port_b_pullup_en, .aio_oe);
`default_nettype wire
